// >>> rtc_i2c_asserts.sv
// Checker for the shared two-wire lines between host and clock device.
`timescale 1ns/100ps
`default_nettype none

module rtc_i2c_asserts (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	// Link signals
	input wire logic scl_host_o,
	input wire logic scl_host_oe,
	input wire logic sda_host_o,
	input wire logic sda_host_oe,
	input wire logic sda_dev_o,
	input wire logic sda_dev_oe,
	input wire logic scl,
	input wire logic sda
);
	// ****************************************
	// Line conditions
	// ****************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence start_s;
		$fell(sda) && scl;
	endsequence
	sequence stop_s;
		$rose(sda) && scl;
	endsequence
	sequence ack_s;
		$rose(scl) && sda_dev_oe;
	endsequence

	dev_open_drain_a: assert property (sda_dev_o == 1'b0)
		else $error("device data drive not low");
	host_open_drain_a: assert property (!scl_host_o && !sda_host_o)
		else $error("host line drive not low");
	dev_hold_high_a: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
		else $error("device data moved in clock high");
	dev_edge_low_a: assert property ($changed(sda_dev_oe) |-> !scl)
		else $error("device data edge in clock high");
	start_clock_low_a: assert property (start_s |-> ##[1:40] !scl)
		else $error("no clock low after start");
	start_idle_a: assert property (start_s |-> $past(scl, 4))
		else $error("start without clock high before");
	stop_release_a: assert property (stop_s |-> (!sda_dev_oe) [*8])
		else $error("device holds data after stop");
	ack_stable_a: assert property (ack_s |-> (!sda) [*8])
		else $error("acknowledge not low in clock high");
endmodule : rtc_i2c_asserts

`default_nettype wire

// >>> rtc_i2c_client.sv
// Device end: two-wire client with clock/SRAM and protected EEPROM spaces.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_i2c_defs.svh"

// Function
// - start is data falling, clock high
// - stop is data rising, clock high
// - host opens with start, closes stop
// - data changes only while clock low
// - one bit per clock high phase
// - host starts only on idle bus
// - host sets byte count, any accepted
// - receiver acknowledges every byte, ninth clock
// - acknowledge holds data low through high
// - no EEPROM acknowledge while programming
// - interface ignored on backup supply
// - host withholds last read acknowledge
// - code 1010 EEPROM, 1101 clock/SRAM
// - host sends chip-select bits all ones
// - control bit zero: one read, zero write
// - valid client address acknowledged, mode set
// - data pin open-drain, never driven high
// - host controls bus, device is client
// - multifunction pin alarm, square, general output
// - external oscillator taken from crystal input
// - no acknowledge for out-of-range addresses
module rtc_i2c_client #(
	parameter int EE_WRITE_CYCLES = `EE_WRITE_CYC
) (
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic reset_n_i,
	// Serial link
	rtc_i2c_if.device bus,
	// Supply, oscillator and alarm inputs
	input  wire logic backup_mode_i,
	input  wire logic crystal_input_pin_i,
	input  wire logic osc_clk_i,
	input  wire logic alarm_level_i,
	// Outputs
	output logic      multi_function_output_o,
	output logic      multi_function_output_oe_o,
	output logic      timekeeping_clk_o,
	output logic      ee_busy_o,
	output logic      selected_o
);
	import rtc_i2c_pkg::*;

	// ****************************************
	// Input synchronisers
	// ****************************************
	// Order: scl, sda, backup, crystal input, oscillator.
	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	logic       scl_q_r;
	logic       sda_q_r;

	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			sync1_r <= 5'h03;
			sync2_r <= 5'h03;
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end
		else
		begin
			sync1_r <= {osc_clk_i, crystal_input_pin_i, backup_mode_i, bus.sda, bus.scl};
			sync2_r <= sync1_r;
			scl_q_r <= sync2_r[0];
			sda_q_r <= sync2_r[1];
		end
	end

	logic scl_s;
	logic sda_s;
	logic backup_s;
	logic start_det;
	logic stop_det;
	logic scl_rise;
	logic scl_fall;

	assign scl_s    = sync2_r[0];
	assign sda_s    = sync2_r[1];
	assign backup_s = sync2_r[2];
	assign start_det = scl_q_r & scl_s & sda_q_r & ~sda_s;
	assign stop_det  = scl_q_r & scl_s & ~sda_q_r & sda_s;
	assign scl_rise  = ~scl_q_r & scl_s;
	assign scl_fall  = scl_q_r & ~scl_s;

	// ****************************************
	// Storage
	// ****************************************
	logic [7:0] rtc_mem [0:95];
	logic [7:0] ee_mem  [0:7];
	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;

	function automatic logic in_range(input logic ee, input logic [7:0] a);
		in_range = ee ? (a >= `EE_FIRST && a <= `EE_LAST) : (a <= `SRAM_LAST);
	endfunction : in_range

	function automatic logic [7:0] next_ptr(input logic ee, input logic [7:0] a);
		if (ee)
			next_ptr = (a == `EE_LAST) ? `EE_FIRST : 8'(a + 8'h01);
		else
			next_ptr = (a == `SRAM_LAST) ? `RTC_FIRST : 8'(a + 8'h01);
	endfunction : next_ptr

	function automatic logic [7:0] rd_byte(input logic ee, input logic [7:0] a);
		if (!in_range(ee, a))
			rd_byte = 8'h00;
		else if (ee)
			rd_byte = ee_mem[a[2:0]];
		else if (a == `CTRL_ADDR)
			rd_byte = ctrl_r;
		else
			rd_byte = rtc_mem[a[6:0]];
	endfunction : rd_byte

	// ****************************************
	// Protocol engine
	// ****************************************
	dev_state_t st_r, st_nxt;
	byte_role_t role_r, role_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [7:0] ptr_r, ptr_nxt;
	logic       ack_r, ack_nxt;
	logic       rd_r, rd_nxt;
	logic       ee_sp_r, ee_sp_nxt;
	logic       sda_oe_r, sda_oe_nxt;
	logic       ee_dirty_r, ee_dirty_nxt;
	logic       mem_we;
	logic       busy_load;
	logic       byte_ok;
	logic [7:0] tx_byte;
	logic [17:0] busy_r, busy_nxt;

	// A continuous assignment would not wake on memory writes hidden behind the function.
	always_comb
	begin
		tx_byte = rd_byte(ee_sp_r, ptr_r);
	end

	always_comb
	begin
		st_nxt       = st_r;
		role_nxt     = role_r;
		cnt_nxt      = cnt_r;
		sh_nxt       = sh_r;
		ptr_nxt      = ptr_r;
		ack_nxt      = ack_r;
		rd_nxt       = rd_r;
		ee_sp_nxt    = ee_sp_r;
		sda_oe_nxt   = sda_oe_r;
		ee_dirty_nxt = ee_dirty_r;
		mem_we       = 1'b0;
		busy_load    = 1'b0;
		byte_ok      = 1'b0;
		if (backup_s)
		begin
			st_nxt     = D_IDLE;
			sda_oe_nxt = 1'b0;
		end
		else if (start_det)
		begin
			st_nxt     = D_RECV;
			role_nxt   = R_CTRL;
			cnt_nxt    = 4'h0;
			sda_oe_nxt = 1'b0;
		end
		else if (stop_det)
		begin
			st_nxt       = D_IDLE;
			sda_oe_nxt   = 1'b0;
			busy_load    = ee_dirty_r;
			ee_dirty_nxt = 1'b0;
		end
		else
		begin
			unique case (st_r)
				D_IDLE, D_IGNORE:
				begin
					sda_oe_nxt = 1'b0;
				end
				D_RECV:
				begin
					if (scl_rise)
					begin
						sh_nxt  = {sh_r[6:0], sda_s};
						cnt_nxt = 4'(cnt_r + 4'h1);
					end
					else if (scl_fall && cnt_r == 4'h8)
					begin
						unique case (role_r)
							R_CTRL:
							begin
								byte_ok = (sh_r[3:1] == `CHIP_SEL) && ((sh_r[7:4] == `CODE_RTC)
									|| (sh_r[7:4] == `CODE_EE && busy_r == 18'h0));
								ee_sp_nxt = (sh_r[7:4] == `CODE_EE);
								rd_nxt   = sh_r[0];
								role_nxt = R_ADDR;
							end
							R_ADDR:
							begin
								byte_ok  = in_range(ee_sp_r, sh_r);
								ptr_nxt  = sh_r;
								role_nxt = R_DATA;
							end
							default:
							begin
								byte_ok      = in_range(ee_sp_r, ptr_r);
								mem_we       = byte_ok;
								ptr_nxt      = next_ptr(ee_sp_r, ptr_r);
								ee_dirty_nxt = ee_dirty_r | (byte_ok & ee_sp_r);
							end
						endcase
						st_nxt     = byte_ok ? D_ACK : D_IGNORE;
						sda_oe_nxt = byte_ok;
					end
				end
				D_ACK:
				begin
					if (scl_fall)
					begin
						cnt_nxt = 4'h0;
						if (rd_r)
						begin
							st_nxt     = D_SEND;
							sh_nxt     = tx_byte;
							ptr_nxt    = next_ptr(ee_sp_r, ptr_r);
							sda_oe_nxt = ~tx_byte[7];
						end
						else
						begin
							st_nxt     = D_RECV;
							sda_oe_nxt = 1'b0;
						end
					end
				end
				D_SEND:
				begin
					if (scl_fall)
					begin
						if (cnt_r == 4'h7)
						begin
							st_nxt     = D_MACK;
							sda_oe_nxt = 1'b0;
						end
						else
						begin
							sh_nxt     = {sh_r[6:0], 1'b0};
							sda_oe_nxt = ~sh_r[6];
							cnt_nxt    = 4'(cnt_r + 4'h1);
						end
					end
				end
				default:
				begin
					if (scl_rise)
						ack_nxt = ~sda_s;
					else if (scl_fall)
					begin
						cnt_nxt = 4'h0;
						if (ack_r)
						begin
							st_nxt     = D_SEND;
							sh_nxt     = tx_byte;
							ptr_nxt    = next_ptr(ee_sp_r, ptr_r);
							sda_oe_nxt = ~tx_byte[7];
						end
						else
							st_nxt = D_IGNORE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			st_r       <= D_IDLE;
			role_r     <= R_CTRL;
			cnt_r      <= 4'h0;
			sh_r       <= 8'h00;
			ptr_r      <= 8'h00;
			ack_r      <= 1'b0;
			rd_r       <= 1'b0;
			ee_sp_r    <= 1'b0;
			sda_oe_r   <= 1'b0;
			ee_dirty_r <= 1'b0;
		end
		else
		begin
			st_r       <= st_nxt;
			role_r     <= role_nxt;
			cnt_r      <= cnt_nxt;
			sh_r       <= sh_nxt;
			ptr_r      <= ptr_nxt;
			ack_r      <= ack_nxt;
			rd_r       <= rd_nxt;
			ee_sp_r    <= ee_sp_nxt;
			sda_oe_r   <= sda_oe_nxt;
			ee_dirty_r <= ee_dirty_nxt;
		end
	end

	// Arrays hold no reset; the control byte does, since it steers the output pin.
	always_ff @(posedge ref_clk_i)
	begin
		if (mem_we && ee_sp_r)
			ee_mem[ptr_r[2:0]] <= sh_r;
		else if (mem_we)
			rtc_mem[ptr_r[6:0]] <= sh_r;
	end

	assign bus.sda_dev_o  = 1'b0;
	assign bus.sda_dev_oe = sda_oe_r;

	// ****************************************
	// EEPROM programming timer and control byte
	// ****************************************
	logic mfp_lvl_r, mfp_lvl_nxt;
	logic tk_clk_r, tk_clk_nxt;

	always_comb
	begin
		busy_nxt = busy_r;
		if (busy_load)
			busy_nxt = 18'(EE_WRITE_CYCLES);
		else if (busy_r != 18'h0)
			busy_nxt = 18'(busy_r - 18'h1);
		ctrl_nxt = (mem_we && !ee_sp_r && ptr_r == `CTRL_ADDR) ? sh_r : ctrl_r;
		tk_clk_nxt = ctrl_r[`CTRL_EXTOSC_BIT] ? sync2_r[3] : sync2_r[4];
		if (ctrl_r[`CTRL_SQWEN_BIT])
			mfp_lvl_nxt = tk_clk_r;
		else if (ctrl_r[`CTRL_ALM0_BIT] || ctrl_r[`CTRL_ALM1_BIT])
			mfp_lvl_nxt = alarm_level_i;
		else
			mfp_lvl_nxt = ctrl_r[`CTRL_OUT_BIT];
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			busy_r    <= 18'h0;
			ctrl_r    <= `CTRL_RESET;
			tk_clk_r  <= 1'b0;
			mfp_lvl_r <= 1'b0;
		end
		else
		begin
			busy_r    <= busy_nxt;
			ctrl_r    <= ctrl_nxt;
			tk_clk_r  <= tk_clk_nxt;
			mfp_lvl_r <= mfp_lvl_nxt;
		end
	end

	assign multi_function_output_o    = 1'b0;
	assign multi_function_output_oe_o = ~mfp_lvl_r;
	assign timekeeping_clk_o          = tk_clk_r;
	assign ee_busy_o                  = (busy_r != 18'h0);
	assign selected_o                 = (st_r != D_IDLE) && (st_r != D_IGNORE);

endmodule : rtc_i2c_client

`default_nettype wire

// >>> rtc_i2c_defs.svh
// Constants of the two-wire clock interface: codes, address ranges, bits and timing.
`ifndef RTC_I2C_DEFS_SVH
`define RTC_I2C_DEFS_SVH

// ****************************************
// Control byte
// ****************************************
`define CODE_EE        4'ha
`define CODE_RTC       4'hd
`define CHIP_SEL       3'h7

// ****************************************
// Address spaces
// ****************************************
`define RTC_FIRST      8'h00
`define SRAM_FIRST     8'h20
`define SRAM_LAST      8'h5f
`define EE_FIRST       8'hf0
`define EE_LAST        8'hf7
`define CTRL_ADDR      8'h07
`define CTRL_RESET     8'h00

// ****************************************
// Control register bit positions
// ****************************************
`define CTRL_OUT_BIT   7
`define CTRL_SQWEN_BIT 6
`define CTRL_ALM1_BIT  5
`define CTRL_ALM0_BIT  4
`define CTRL_EXTOSC_BIT 3

// ****************************************
// Timing
// ****************************************
`define REF_CLK_KHZ    50000
`define T_EE_WRITE_MS  5
`define EE_WRITE_CYC   (`T_EE_WRITE_MS * `REF_CLK_KHZ)
`define T_STEP_NS      650
`define STEP_CYC       ((`T_STEP_NS * `REF_CLK_KHZ + 999999) / 1000000)

`endif

// >>> rtc_i2c_host.sv
// Host end: write-data FIFO and two-wire bus controller.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_i2c_defs.svh"

module rtc_i2c_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             ref_clk_i,
	input  wire logic             reset_n_i,
	// Fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW:0]      wp_r, wp_nxt;
	logic [AW:0]      rp_r, rp_nxt;

	assign out_valid_o = (wp_r != rp_r);
	assign in_ready_o  = (wp_r[AW-1:0] != rp_r[AW-1:0]) || (wp_r[AW] == rp_r[AW]);
	assign out_data_o  = mem[rp_r[AW-1:0]];

	always_comb
	begin
		wp_nxt = (in_valid_i && in_ready_o) ? (AW+1)'(wp_r + 1'b1) : wp_r;
		rp_nxt = (out_valid_o && out_ready_i) ? (AW+1)'(rp_r + 1'b1) : rp_r;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			wp_r <= '0;
			rp_r <= '0;
		end
		else
		begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (in_valid_i && in_ready_o)
			mem[wp_r[AW-1:0]] <= in_data_i;
	end
endmodule : rtc_i2c_fifo

module rtc_i2c_host #(
	parameter int STEP_CYCLES = `STEP_CYC,
	parameter int FIFO_DEPTH  = 32
) (
	// Clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       reset_n_i,
	// Serial link
	rtc_i2c_if.host         bus,
	// Command
	input  wire logic       cmd_valid_i,
	output logic            cmd_ready_o,
	input  wire logic       cmd_read_i,
	input  wire logic       cmd_eeprom_i,
	input  wire logic [7:0] cmd_addr_i,
	input  wire logic [7:0] cmd_len_i,
	// Write data
	input  wire logic       wr_valid_i,
	output logic            wr_ready_o,
	input  wire logic [7:0] wr_data_i,
	// Read data and status
	output logic            rd_valid_o,
	output logic      [7:0] rd_data_o,
	output logic            done_o,
	output logic            nack_o
);
	import rtc_i2c_pkg::*;

	logic       f_valid;
	logic       f_pop;
	logic [7:0] f_data;

	rtc_i2c_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rtc_i2c_fifo_inst (
		.ref_clk_i   (ref_clk_i),
		.reset_n_i   (reset_n_i),
		.in_valid_i  (wr_valid_i),
		.in_ready_o  (wr_ready_o),
		.in_data_i   (wr_data_i),
		.out_valid_o (f_valid),
		.out_ready_i (f_pop),
		.out_data_o  (f_data)
	);

	// ****************************************
	// Data line synchroniser
	// ****************************************
	logic sda1_r;
	logic sda2_r;

	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			sda1_r <= 1'b1;
			sda2_r <= 1'b1;
		end
		else
		begin
			sda1_r <= bus.sda;
			sda2_r <= sda1_r;
		end
	end

	// ****************************************
	// Bus controller
	// ****************************************
	host_state_t hst_r, hst_nxt;
	host_stage_t stg_r, stg_nxt;
	logic [1:0]  ph_r, ph_nxt;
	logic [7:0]  div_r, div_nxt;
	logic [3:0]  bit_r, bit_nxt;
	logic [7:0]  tx_r, tx_nxt, rx_r, rx_nxt;
	logic [7:0]  left_r, left_nxt, addr_r, addr_nxt;
	logic        read_r, read_nxt, ee_r, ee_nxt, nak_r, nak_nxt;
	logic        scl_oe_r, scl_oe_nxt, sda_oe_r, sda_oe_nxt;
	logic        rdv_r, rdv_nxt, done_r, done_nxt, nack_r, nack_nxt;
	logic [7:0]  rdd_r, rdd_nxt;
	logic        tick;
	logic        tx_stage;
	logic [7:0]  ctrl_byte;

	assign tick        = (div_r == 8'(STEP_CYCLES - 1));
	assign tx_stage    = (stg_r != S_RDATA);
	assign ctrl_byte   = {ee_r ? `CODE_EE : `CODE_RTC, `CHIP_SEL, 1'b0};
	assign cmd_ready_o = (hst_r == H_IDLE);

	always_comb
	begin
		hst_nxt = hst_r;
		stg_nxt = stg_r;
		{ph_nxt, bit_nxt, tx_nxt, rx_nxt} = {ph_r, bit_r, tx_r, rx_r};
		{left_nxt, addr_nxt, read_nxt, ee_nxt, nak_nxt} = {left_r, addr_r, read_r, ee_r, nak_r};
		{scl_oe_nxt, sda_oe_nxt, rdd_nxt, nack_nxt} = {scl_oe_r, sda_oe_r, rdd_r, nack_r};
		div_nxt  = (hst_r == H_IDLE || tick) ? 8'h00 : 8'(div_r + 8'h01);
		rdv_nxt  = 1'b0;
		done_nxt = 1'b0;
		f_pop    = 1'b0;
		if (hst_r == H_IDLE && cmd_valid_i)
		begin
			hst_nxt  = H_START;
			stg_nxt  = S_CTRLW;
			ph_nxt   = 2'h0;
			read_nxt = cmd_read_i;
			ee_nxt   = cmd_eeprom_i;
			addr_nxt = cmd_addr_i;
			left_nxt = (cmd_read_i && cmd_len_i == 8'h00) ? 8'h01 : cmd_len_i;
			nack_nxt = 1'b0;
		end
		else if (hst_r != H_IDLE && tick)
		begin
			ph_nxt = 2'(ph_r + 2'h1);
			unique case (hst_r)
				H_START:
				begin
					unique case (ph_r)
						2'h0: sda_oe_nxt = 1'b0;
						2'h1: scl_oe_nxt = 1'b0;
						2'h2: sda_oe_nxt = 1'b1;
						default:
						begin
							scl_oe_nxt = 1'b1;
							hst_nxt    = H_BIT;
							bit_nxt    = 4'h0;
							tx_nxt     = (stg_r == S_CTRLR) ? {ctrl_byte[7:1], 1'b1} : ctrl_byte;
						end
					endcase
				end
				H_BIT:
				begin
					unique case (ph_r)
						2'h0:
						begin
							if (bit_r != 4'h8)
								sda_oe_nxt = tx_stage & ~tx_r[7];
							else
								sda_oe_nxt = ~tx_stage & (left_r != 8'h01);
						end
						2'h1: scl_oe_nxt = 1'b0;
						2'h2:
						begin
							if (bit_r != 4'h8)
								rx_nxt = {rx_r[6:0], sda2_r};
							else
								nak_nxt = tx_stage & sda2_r;
						end
						default:
						begin
							scl_oe_nxt = 1'b1;
							bit_nxt    = 4'(bit_r + 4'h1);
							tx_nxt     = {tx_r[6:0], 1'b0};
							if (bit_r == 4'h8)
							begin
								bit_nxt = 4'h0;
								if (nak_r)
								begin
									hst_nxt  = H_STOP;
									nack_nxt = 1'b1;
								end
								else
								begin
									unique case (stg_r)
										S_CTRLW:
										begin
											stg_nxt = S_ADDR;
											tx_nxt  = addr_r;
										end
										S_CTRLR: stg_nxt = S_RDATA;
										S_RDATA:
										begin
											rdv_nxt  = 1'b1;
											rdd_nxt  = rx_r;
											left_nxt = 8'(left_r - 8'h01);
											hst_nxt  = (left_r == 8'h01) ? H_STOP : H_BIT;
										end
										default:
										begin
											if (stg_r == S_ADDR && read_r)
											begin
												stg_nxt = S_CTRLR;
												hst_nxt = H_START;
											end
											else if (stg_r == S_WDATA && left_r == 8'h01 || left_r == 8'h00)
												hst_nxt = H_STOP;
											else if (f_valid)
											begin
												f_pop    = 1'b1;
												tx_nxt   = f_data;
												stg_nxt  = S_WDATA;
												left_nxt = (stg_r == S_WDATA) ? 8'(left_r - 8'h01) : left_r;
											end
											else
											begin
												// An empty FIFO stretches the low phase.
												ph_nxt  = ph_r;
												bit_nxt = bit_r;
											end
										end
									endcase
								end
							end
						end
					endcase
				end
				default:
				begin
					unique case (ph_r)
						2'h0: sda_oe_nxt = 1'b1;
						2'h1: scl_oe_nxt = 1'b0;
						2'h2: sda_oe_nxt = 1'b0;
						default:
						begin
							hst_nxt  = H_IDLE;
							done_nxt = 1'b1;
						end
					endcase
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			hst_r <= H_IDLE;
			stg_r <= S_CTRLW;
			{ph_r, bit_r, tx_r, rx_r} <= {2'h0, 4'h0, 8'h00, 8'h00};
			{left_r, addr_r, read_r, ee_r, nak_r, div_r} <= {8'h00, 8'h00, 3'h0, 8'h00};
			{scl_oe_r, sda_oe_r, rdv_r, rdd_r, done_r, nack_r} <= {3'h0, 8'h00, 2'h0};
		end
		else
		begin
			hst_r <= hst_nxt;
			stg_r <= stg_nxt;
			{ph_r, bit_r, tx_r, rx_r} <= {ph_nxt, bit_nxt, tx_nxt, rx_nxt};
			{left_r, addr_r, read_r, ee_r, nak_r, div_r} <= {left_nxt, addr_nxt, read_nxt, ee_nxt,
				nak_nxt, div_nxt};
			{scl_oe_r, sda_oe_r, rdv_r, rdd_r, done_r, nack_r} <= {scl_oe_nxt, sda_oe_nxt, rdv_nxt,
				rdd_nxt, done_nxt, nack_nxt};
		end
	end

	assign bus.scl_host_o  = 1'b0;
	assign bus.scl_host_oe = scl_oe_r;
	assign bus.sda_host_o  = 1'b0;
	assign bus.sda_host_oe = sda_oe_r;
	assign rd_valid_o      = rdv_r;
	assign rd_data_o       = rdd_r;
	assign done_o          = done_r;
	assign nack_o          = nack_r;

endmodule : rtc_i2c_host

`default_nettype wire

// >>> rtc_i2c_if.sv
// Open-drain two-wire link between bus host and clock device.
`timescale 1ns/100ps
`default_nettype none

interface rtc_i2c_if;
	logic scl_host_o;
	logic scl_host_oe;
	logic sda_host_o;
	logic sda_host_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic scl;
	logic sda;

	// A driven open-drain pin pulls low; released lines float high by pull-up.
	assign scl = scl_host_oe ? scl_host_o : 1'b1;
	assign sda = (sda_host_oe || sda_dev_oe) ? (sda_host_o & sda_dev_o) | ~(sda_host_oe | sda_dev_oe)
		: 1'b1;

	modport host (
		output scl_host_o,
		output scl_host_oe,
		output sda_host_o,
		output sda_host_oe,
		input  sda
	);

	modport device (
		output sda_dev_o,
		output sda_dev_oe,
		input  scl,
		input  sda
	);
endinterface : rtc_i2c_if

`default_nettype wire

// >>> rtc_i2c_pkg.sv
// Types shared by both ends of the two-wire clock interface.
package rtc_i2c_pkg;

	typedef enum logic [2:0] {
		D_IDLE   = 3'b000,
		D_RECV   = 3'b001,
		D_ACK    = 3'b010,
		D_SEND   = 3'b011,
		D_MACK   = 3'b100,
		D_IGNORE = 3'b101
	} dev_state_t;

	typedef enum logic [1:0] {
		R_CTRL = 2'b00,
		R_ADDR = 2'b01,
		R_DATA = 2'b10
	} byte_role_t;

	typedef enum logic [1:0] {
		H_IDLE  = 2'b00,
		H_START = 2'b01,
		H_BIT   = 2'b10,
		H_STOP  = 2'b11
	} host_state_t;

	typedef enum logic [2:0] {
		S_CTRLW = 3'b000,
		S_ADDR  = 3'b001,
		S_WDATA = 3'b010,
		S_CTRLR = 3'b011,
		S_RDATA = 3'b100
	} host_stage_t;

endpackage : rtc_i2c_pkg

// >>> tb_rtc_i2c_client_interface.sv
// Testbench: host and clock device joined across the two-wire link.
`timescale 1ns/100ps
`default_nettype none

module tb_rtc_i2c_client_interface;
	logic ref_clk_i, reset_n_i, backup_mode_i, xtal_i, osc_i, alarm_i;
	logic mfo, mfo_oe, tk_clk, ee_busy, sel;
	logic cmd_valid_i, cmd_ready_o, cmd_read_i, cmd_eeprom_i;
	logic [7:0] cmd_addr_i, cmd_len_i, wr_data_i, rd_data_o;
	logic wr_valid_i, wr_ready_o, rd_valid_o, done_o, nack_o, sel_seen;
	logic [7:0] rdq[$];
	int fail_count, tests_run, cyc;

	rtc_i2c_if rtc_i2c_if_inst ();
	// A short programming time keeps the busy window across the next two commands.
	rtc_i2c_client #(.EE_WRITE_CYCLES(2000)) rtc_i2c_client_inst (.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i), .bus(rtc_i2c_if_inst), .backup_mode_i(backup_mode_i),
		.crystal_input_pin_i(xtal_i), .osc_clk_i(osc_i), .alarm_level_i(alarm_i),
		.multi_function_output_o(mfo), .multi_function_output_oe_o(mfo_oe),
		.timekeeping_clk_o(tk_clk), .ee_busy_o(ee_busy), .selected_o(sel));
	rtc_i2c_host #(.STEP_CYCLES(8), .FIFO_DEPTH(32)) rtc_i2c_host_inst (.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i), .bus(rtc_i2c_if_inst), .cmd_valid_i(cmd_valid_i),
		.cmd_ready_o(cmd_ready_o), .cmd_read_i(cmd_read_i), .cmd_eeprom_i(cmd_eeprom_i),
		.cmd_addr_i(cmd_addr_i), .cmd_len_i(cmd_len_i), .wr_valid_i(wr_valid_i),
		.wr_ready_o(wr_ready_o), .wr_data_i(wr_data_i), .rd_valid_o(rd_valid_o),
		.rd_data_o(rd_data_o), .done_o(done_o), .nack_o(nack_o));
	rtc_i2c_asserts rtc_i2c_asserts_inst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.scl_host_o(rtc_i2c_if_inst.scl_host_o), .scl_host_oe(rtc_i2c_if_inst.scl_host_oe),
		.sda_host_o(rtc_i2c_if_inst.sda_host_o), .sda_host_oe(rtc_i2c_if_inst.sda_host_oe),
		.sda_dev_o(rtc_i2c_if_inst.sda_dev_o), .sda_dev_oe(rtc_i2c_if_inst.sda_dev_oe),
		.scl(rtc_i2c_if_inst.scl), .sda(rtc_i2c_if_inst.sda));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("BAD %s exp %h got %h", nm, e, g);
			fail_count++;
		end
	endtask : chk

	task automatic push(input logic [7:0] d);
		@(posedge ref_clk_i) #1;
		wr_valid_i = 1'b1;
		wr_data_i = d;
		@(posedge ref_clk_i) #1;
		wr_valid_i = 1'b0;
	endtask : push

	task automatic cmd(input logic rd, ee, input logic [7:0] a, n);
		int k;
		k = 0;
		while (cmd_ready_o !== 1'b1) @(posedge ref_clk_i) #1;
		{cmd_read_i, cmd_eeprom_i, cmd_addr_i, cmd_len_i} = {rd, ee, a, n};
		cmd_valid_i = 1'b1;
		@(posedge ref_clk_i) #1;
		cmd_valid_i = 1'b0;
		rdq = {};
		sel_seen = 1'b0;
		while (done_o !== 1'b1 && k < 30000)
		begin
			@(posedge ref_clk_i) #1;
			k++;
		end
		chk("done", 8'h01, {7'h00, done_o});
	endtask : cmd

	task test_done;
		$display("tests_run %0d fail_count %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic s_fill;
		for (int i = 0; i < 32; i++)
			push(8'h30 + 8'(i));
		chk("fifo full", 8'h00, {7'h00, wr_ready_o});
		cmd(1'b0, 1'b0, 8'h20, 8'h20);
		chk("wr nack", 8'h00, {7'h00, nack_o});
		chk("fifo empty", 8'h01, {7'h00, wr_ready_o});
		cmd(1'b1, 1'b0, 8'h20, 8'h20);
		chk("rd count", 8'h20, 8'(rdq.size()));
		for (int i = 0; i < 32; i++)
			chk("rd byte", 8'h30 + 8'(i), rdq[i]);
	endtask : s_fill

	task automatic s_eeprom;
		int k;
		k = 0;
		push(8'ha5);
		cmd(1'b0, 1'b1, 8'hf0, 8'h01);
		chk("ee busy", 8'h01, {7'h00, ee_busy});
		cmd(1'b1, 1'b1, 8'hf0, 8'h01);
		chk("ee refused", 8'h01, {7'h00, nack_o});
		cmd(1'b1, 1'b0, 8'h20, 8'h01);
		chk("ram in busy", 8'h30, rdq[0]);
		chk("still busy", 8'h01, {7'h00, ee_busy});
		while (ee_busy !== 1'b0 && k < 3000)
		begin
			@(posedge ref_clk_i) #1;
			k++;
		end
		chk("ee idle", 8'h00, {7'h00, ee_busy});
		cmd(1'b1, 1'b1, 8'hf0, 8'h01);
		chk("ee byte", 8'ha5, rdq[0]);
		cmd(1'b0, 1'b0, 8'h60, 8'h00);
		chk("range nack", 8'h01, {7'h00, nack_o});
	endtask : s_eeprom

	task automatic s_pins;
		backup_mode_i = 1'b1;
		cmd(1'b0, 1'b0, 8'h20, 8'h00);
		chk("backup nack", 8'h01, {7'h00, nack_o});
		chk("backup sel", 8'h00, {7'h00, sel_seen});
		backup_mode_i = 1'b0;
		push(8'h80);
		cmd(1'b0, 1'b0, 8'h07, 8'h01);
		chk("sel seen", 8'h01, {7'h00, sel_seen});
		chk("out high", 8'h00, {7'h00, mfo_oe});
		push(8'h08);
		cmd(1'b0, 1'b0, 8'h07, 8'h01);
		chk("out low", 8'h01, {7'h00, mfo_oe});
		{xtal_i, osc_i} = 2'b10;
		repeat (6) @(posedge ref_clk_i) #1;
		chk("ext clk hi", 8'h01, {7'h00, tk_clk});
		{xtal_i, osc_i} = 2'b01;
		repeat (6) @(posedge ref_clk_i) #1;
		chk("ext clk lo", 8'h00, {7'h00, tk_clk});
		push(8'h10);
		cmd(1'b0, 1'b0, 8'h07, 8'h01);
		alarm_i = 1'b1;
		repeat (2) @(posedge ref_clk_i) #1;
		chk("alarm out", 8'h00, {7'h00, mfo_oe});
		alarm_i = 1'b0;
		push(8'h48);
		cmd(1'b0, 1'b0, 8'h07, 8'h01);
		chk("square low", 8'h01, {7'h00, mfo_oe});
		xtal_i = 1'b1;
		repeat (6) @(posedge ref_clk_i) #1;
		chk("square high", 8'h00, {7'h00, mfo_oe});
	endtask : s_pins

	initial
	begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end

	always @(posedge ref_clk_i)
	begin
		if (rd_valid_o === 1'b1)
			rdq.push_back(rd_data_o);
		if (sel === 1'b1)
			sel_seen = 1'b1;
		cyc++;
		if (cyc == 60000)
		begin
			fail_count++;
			test_done();
		end
	end

	initial
	begin
		{reset_n_i, backup_mode_i, xtal_i, osc_i, alarm_i} = 5'h00;
		{cmd_valid_i, cmd_read_i, cmd_eeprom_i, wr_valid_i} = 4'h0;
		{cmd_addr_i, cmd_len_i, wr_data_i} = 24'h000000;
		repeat (8) @(posedge ref_clk_i);
		#1 reset_n_i = 1'b1;
		@(posedge ref_clk_i) #1;
		chk("reset idle", 8'h03, {6'h00, cmd_ready_o, wr_ready_o});
		chk("reset pins", 8'h01, {6'h00, ee_busy, mfo_oe});
		chk("reset sel", 8'h00, {6'h00, mfo, sel});
		s_fill();
		s_eeprom();
		s_pins();
		test_done();
	end
endmodule : tb_rtc_i2c_client_interface

`default_nettype wire
